/* src/jbm_cfg.svh */
// Purpose: constants for the jtag bridge mode-register block
// Assumes: one backplane test clock domain
// Notes: offsets are data-register selects, not bus addresses
`ifndef JBM_CFG_SVH
`define JBM_CFG_SVH

// ************************************************************
// register reset values
// ************************************************************
`define JBM_PRIMARY_RESET 8'h01
`define JBM_EXTENSION_RESET 8'h00
`define JBM_GPIO_SEL_RESET 8'h00

// ************************************************************
// field positions of the primary configuration register
// ************************************************************
`define JBM_BIT_PORT0 0
`define JBM_BIT_PORT2 2
`define JBM_BIT_TCK_STOP 3
`define JBM_BIT_LOOPBACK 4
`define JBM_BIT_PORT3 5
`define JBM_BIT_PORT4 6
`define JBM_BIT_CNT_STATUS 7
// extension register: ports 5..7 in bits 0..2, bits above reserved
`define JBM_EXT_USED_MASK 8'h07

// ************************************************************
// timing
// ************************************************************
// backplane clock pulses counted in the parked reset state
`define JBM_PARK_GATE_PULSES 10'h200
`define JBM_PARK_CNT_W 10
// backplane clock period in ns (10 MHz)
`define JBM_CLOCK_PERIOD_NS 100

`endif

/* src/jbm_pkg.sv */
// Purpose: types for the jtag bridge mode-register block
// Assumes: constants come from jbm_cfg.svh
// Notes: all widths fixed at the eight-port maximum
package jbm_pkg;

  // ************************************************************
  // local port park state, as reported by the bridge sequencer
  // ************************************************************
  typedef enum logic [1:0] {
    JBM_UNPARKED = 2'b00,
    JBM_PARKED_IDLE = 2'b01,
    JBM_PARKED_PAUSE = 2'b10,
    JBM_PARKED_RESET = 2'b11
  } jbm_park_e;

  // ************************************************************
  // data register selected by the current instruction
  // ************************************************************
  typedef enum logic [2:0] {
    JBM_SEL_OTHER = 3'b000,
    JBM_SEL_PRIMARY = 3'b001,
    JBM_SEL_EXTENSION = 3'b010,
    JBM_SEL_GPIO = 3'b011,
    JBM_SEL_COUNTER = 3'b100
  } jbm_dr_sel_e;

  // tap controller phase strobes, one cycle each except shift_dr
  typedef struct packed {
    logic test_logic_reset;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
  } jbm_tap_s;

  // counter state seen from outside
  typedef struct packed {
    logic enabled;
    logic at_zero;
  } jbm_counter_s;

  // whole block state
  typedef struct packed {
    logic [7:0] primary;
    logic [7:0] extension;
    logic [7:0] gpio_select;
    logic cnt_status;
    logic [7:0] shifter;
    logic [7:0] pad;
    logic [9:0] park_cnt;
  } jbm_state_s;

endpackage

/* src/jbm_mode_regs.sv */
// Purpose: mode registers and local scan port chain routing
// Assumes: tap strobes, park state and counter flags on this clock
// Notes: counter, instruction decode and gpio data live elsewhere
//
// Contract
// - loopback bit 4 routes own register to backplane tdo, ports ignored
// - parked idle or pause: bit 3 high stops local clocks, low frees; counter enabled at zero also stops them
// - parked reset: local clocks stop after 512 backplane pulses, any bit 3
// - status bit 7 high only while counter enabled and at zero
// - status bit 7 cleared when counter loaded after counter select
// - status bit reads zero after power-on
// - selected ports chained ascending after own register, each with pad
// - primary bits 0-2 select ports 0-2, bits 5-6 ports 3-4
// - extension bits 0-2 select ports 5-7, rest reserved, reset zero
// - test logic reset loads primary register with 8'h01
// - all ports parked: only own register between tdi and tdo
`timescale 1ns/10ps
`include "jbm_cfg.svh"

module jbm_mode_regs #(
  parameter int NUM_PORTS = 8
) (
  input wire logic clock,
  input wire logic reset,
  input wire jbm_pkg::jbm_tap_s tap,
  input wire jbm_pkg::jbm_dr_sel_e dr_select,
  input wire jbm_pkg::jbm_park_e park_state,
  input wire jbm_pkg::jbm_counter_s counter,
  input wire logic backplane_tdi,
  input wire logic other_reg_so,
  input wire logic [NUM_PORTS-1:0] local_port_tdo,
  output logic [NUM_PORTS-1:0] local_port_tdi,
  output logic backplane_tdo,
  output logic local_tck_enable,
  output logic [7:0] port_chain_config_primary,
  output logic [7:0] port_chain_config_extension,
  output logic [7:0] port_gpio_select,
  output logic counter_status
);

  // ************************************************************
  // writable bit masks by build size
  // ************************************************************
  // bit 5 exists in four-port builds and up, bit 6 in five-port builds and up
  localparam logic [7:0] PRIMARY_MASK =
    (NUM_PORTS >= 5) ? 8'h7f :
    (NUM_PORTS == 4) ? 8'h3f : 8'h1f;
  localparam logic [7:0] EXT_MASK =
    (NUM_PORTS >= 8) ? `JBM_EXT_USED_MASK :
    (NUM_PORTS == 7) ? 8'h03 :
    (NUM_PORTS == 6) ? 8'h01 : 8'h00;
  localparam logic [7:0] GPIO_MASK =
    (NUM_PORTS >= 8) ? 8'hff : 8'((16'h0001 << NUM_PORTS) - 16'h0001);

  jbm_pkg::jbm_state_s s_reg;
  jbm_pkg::jbm_state_s s_next;

  logic mode_selected;
  logic reg_so;
  logic all_parked;
  logic loopback;
  logic [7:0] port_select;
  logic [7:0] chain_select;
  logic [7:0] stage_in;
  logic chain_out;
  logic counter_load;
  logic park_gate_done;

  // ************************************************************
  // selection and routing terms
  // ************************************************************
  // our own shifter feeds the chain only when a mode register is chosen
  assign mode_selected = (dr_select == jbm_pkg::JBM_SEL_PRIMARY) ||
                         (dr_select == jbm_pkg::JBM_SEL_EXTENSION) ||
                         (dr_select == jbm_pkg::JBM_SEL_GPIO);
  assign reg_so = mode_selected ? s_reg.shifter[0] : other_reg_so;
  assign all_parked = (park_state != jbm_pkg::JBM_UNPARKED);
  assign loopback = s_reg.primary[`JBM_BIT_LOOPBACK];

  // port select vector in port order 0..7
  assign port_select = {
    s_reg.extension[2:0],
    s_reg.primary[`JBM_BIT_PORT4:`JBM_BIT_PORT3],
    s_reg.primary[`JBM_BIT_PORT2:`JBM_BIT_PORT0]
  };

  // loopback and full park both collapse the chain to our register
  assign chain_select = (loopback || all_parked) ? 8'h00 : port_select;

  assign counter_load = tap.update_dr &&
                        (dr_select == jbm_pkg::JBM_SEL_COUNTER);
  assign park_gate_done = (s_reg.park_cnt >= `JBM_PARK_GATE_PULSES);

  // ************************************************************
  // local scan port network
  // ************************************************************
  // each chained port is followed by its pad flop; skipped ports pass
  // the stream straight on, so order is always ascending
  always_comb begin
    logic link;
    link = reg_so;
    stage_in = 8'h00;
    for (int k = 0; k < 8; k++) begin
      stage_in[k] = link;
      if (chain_select[k] && (k < NUM_PORTS)) begin
        link = s_reg.pad[k];
      end
    end
    chain_out = link;
  end

  // unchained ports see a quiet low on their tdi
  always_comb begin
    for (int k = 0; k < NUM_PORTS; k++) begin
      local_port_tdi[k] = chain_select[k] ? stage_in[k] : 1'b0;
    end
  end

  assign backplane_tdo = chain_out;

  // ************************************************************
  // local test clock gating
  // ************************************************************
  // bit 3 only matters in idle or pause park; keeping it low lets targets keep
  // clocking during idle or pause park, which most boards expect
  always_comb begin
    local_tck_enable = 1'b1;
    unique case (park_state)
      jbm_pkg::JBM_UNPARKED: begin
        local_tck_enable = 1'b1;
      end
      jbm_pkg::JBM_PARKED_IDLE, jbm_pkg::JBM_PARKED_PAUSE: begin
        local_tck_enable = !s_reg.primary[`JBM_BIT_TCK_STOP];
      end
      jbm_pkg::JBM_PARKED_RESET: begin
        local_tck_enable = !park_gate_done;
      end
    endcase
    // a parked port running bist stops once the counter expires
    if (all_parked && counter.enabled && counter.at_zero) begin
      local_tck_enable = 1'b0;
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_next = s_reg;

    // parked reset pulse count, saturating so it never wraps back on
    if (park_state == jbm_pkg::JBM_PARKED_RESET) begin
      if (!park_gate_done) begin
        s_next.park_cnt = s_reg.park_cnt + 10'h001;
      end
    end else begin
      s_next.park_cnt = '0;
    end

    // pad bits shift with the data register stream
    if (tap.shift_dr) begin
      for (int k = 0; k < NUM_PORTS; k++) begin
        if (chain_select[k]) begin
          s_next.pad[k] = local_port_tdo[k];
        end
      end
    end

    // status follows the counter; a load drops it unless the set
    // condition holds in that same cycle, since set must win
    if (counter.enabled && counter.at_zero) begin
      s_next.cnt_status = 1'b1;
    end else if (counter_load) begin
      s_next.cnt_status = 1'b0;
    end else begin
      s_next.cnt_status = 1'b0;
    end

    // capture, shift and update of the selected mode register
    if (mode_selected) begin
      if (tap.capture_dr) begin
        unique case (dr_select)
          jbm_pkg::JBM_SEL_PRIMARY: begin
            s_next.shifter = {s_reg.cnt_status, s_reg.primary[6:0]};
          end
          jbm_pkg::JBM_SEL_EXTENSION: begin
            s_next.shifter = s_reg.extension & EXT_MASK;
          end
          default: begin
            s_next.shifter = s_reg.gpio_select;
          end
        endcase
      end else if (tap.shift_dr) begin
        s_next.shifter = {backplane_tdi, s_reg.shifter[7:1]};
      end else if (tap.update_dr) begin
        unique case (dr_select)
          jbm_pkg::JBM_SEL_PRIMARY: begin
            // bit 7 position is dropped on update
            s_next.primary = s_reg.shifter & PRIMARY_MASK;
          end
          jbm_pkg::JBM_SEL_EXTENSION: begin
            s_next.extension = s_reg.shifter & EXT_MASK;
          end
          default: begin
            s_next.gpio_select = s_reg.shifter & GPIO_MASK;
          end
        endcase
      end
    end

    // synchronous re-initialisation from the tap reset state
    if (tap.test_logic_reset) begin
      s_next.primary = `JBM_PRIMARY_RESET;
      s_next.extension = `JBM_EXTENSION_RESET;
      s_next.gpio_select = `JBM_GPIO_SEL_RESET;
      s_next.shifter = '0;
      s_next.pad = '0;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_reg.primary <= `JBM_PRIMARY_RESET;
      s_reg.extension <= `JBM_EXTENSION_RESET;
      s_reg.gpio_select <= `JBM_GPIO_SEL_RESET;
      s_reg.cnt_status <= 1'b0;
      s_reg.shifter <= '0;
      s_reg.pad <= '0;
      s_reg.park_cnt <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ************************************************************
  // register views
  // ************************************************************
  assign port_chain_config_primary = {s_reg.cnt_status, s_reg.primary[6:0]};
  assign port_chain_config_extension = s_reg.extension & EXT_MASK;
  assign port_gpio_select = s_reg.gpio_select;
  assign counter_status = s_reg.cnt_status;

endmodule // jbm_mode_regs

/* dv/jbm_mode_regs_assertions.sv */
// Purpose: port-level checks of the mode-register block
// Assumes: one clock, async active-high reset
// Notes: bound into every jbm_mode_regs instance
`timescale 1ns/10ps
module jbm_mode_regs_chk #(
  parameter int NUM_PORTS = 8
) (
  input wire logic clock,
  input wire logic reset,
  input wire jbm_pkg::jbm_tap_s tap,
  input wire jbm_pkg::jbm_park_e park_state,
  input wire jbm_pkg::jbm_counter_s counter,
  input wire logic [NUM_PORTS-1:0] local_port_tdi,
  input wire logic local_tck_enable,
  input wire logic [7:0] port_chain_config_primary,
  input wire logic [7:0] port_chain_config_extension,
  input wire logic counter_status
);
  // ************************************************************
  // helpers
  // ************************************************************
  logic [10:0] park_cnt_reg;
  logic hit;
  logic in_rst;
  assign hit = counter.enabled && counter.at_zero;
  assign in_rst = park_state == jbm_pkg::JBM_PARKED_RESET;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // edges spent in parked reset; saturates so it never wraps
  always_ff @(posedge clock or posedge reset) begin
    if (reset || !in_rst) begin
      park_cnt_reg <= 11'h000;
    end else if (park_cnt_reg < 11'h3e8) begin
      park_cnt_reg <= park_cnt_reg + 11'h001;
    end
  end
  chk_status_set: assert property (hit |=> counter_status)
    else $error("status not set at terminal count");
  chk_status_clear: assert property (!hit |=> !counter_status)
    else $error("status set without terminal count");
  chk_status_bit: assert property (port_chain_config_primary[7] == counter_status)
    else $error("status bit differs from status");
  chk_loop_quiet: assert property (port_chain_config_primary[4] |-> local_port_tdi == '0)
    else $error("local port fed in loopback");
  chk_park_quiet: assert property (park_state != jbm_pkg::JBM_UNPARKED |-> local_port_tdi == '0)
    else $error("local port fed while parked");
  chk_idle_gate: assert property ((park_state inside {jbm_pkg::JBM_PARKED_IDLE,
    jbm_pkg::JBM_PARKED_PAUSE}) && !hit |-> local_tck_enable == !port_chain_config_primary[3])
    else $error("idle clock gate wrong");
  chk_free_run: assert property (park_state == jbm_pkg::JBM_UNPARKED |-> local_tck_enable)
    else $error("local clock stopped while unparked");
  chk_reset_gate: assert property (in_rst && !hit |-> local_tck_enable == (park_cnt_reg < 11'h200))
    else $error("parked reset gate count wrong");
  chk_ext_rsvd: assert property (port_chain_config_extension[7:3] == 5'h00)
    else $error("reserved extension bits set");
  chk_tlr_load: assert property (tap.test_logic_reset |=> port_chain_config_primary[6:0] == 7'h01
    && port_chain_config_extension == 8'h00) else $error("tap reset values wrong");
  // main scenarios reached
  cover property (hit ##1 counter_status);
  cover property (in_rst && park_cnt_reg == 11'h200);
  cover property (port_chain_config_primary[4] && park_state == jbm_pkg::JBM_UNPARKED);
endmodule // jbm_mode_regs_chk
bind jbm_mode_regs jbm_mode_regs_chk #(.NUM_PORTS(NUM_PORTS)) chk (.*);

/* dv/jbm_local_chain.sv */
// Purpose: local target chains, one capture stage per port
// Assumes: stages move on the backplane clock while shift_dr is high
// Notes: starts at ones so stale data is never mistaken for zeros
`timescale 1ns/10ps
module jbm_local_chain #(
  parameter int NUM_PORTS = 8
) (
  input wire logic clock,
  input wire logic shift,
  input wire logic [NUM_PORTS-1:0] tdi,
  output logic [NUM_PORTS-1:0] tdo
);
  initial tdo = '1;
  // one stage per port, like a single bypass bit
  always @(posedge clock) begin
    if (shift) begin
      tdo <= tdi;
    end
  end
endmodule // jbm_local_chain

/* dv/testbench.sv */
// Purpose: scan-driven test of the mode-register block
// Assumes: inputs change 1 ns after the rising edge
// Notes: other register serial out is tied low
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
  logic clock, reset, tdi, tdo, tck_en, status;
  jbm_pkg::jbm_tap_s tap;
  jbm_pkg::jbm_dr_sel_e sel;
  jbm_pkg::jbm_park_e park;
  jbm_pkg::jbm_counter_s cnt;
  logic [7:0] lp_tdo, lp_tdi, pri, ext, gsel;
  logic [31:0] q;
  int bad_count = 0, n_tests = 0, cyc = 0;
  jbm_mode_regs dut (.clock(clock), .reset(reset), .tap(tap), .dr_select(sel),
    .park_state(park), .counter(cnt), .backplane_tdi(tdi), .other_reg_so(1'b0),
    .local_port_tdo(lp_tdo), .local_port_tdi(lp_tdi), .backplane_tdo(tdo),
    .local_tck_enable(tck_en), .port_chain_config_primary(pri),
    .port_chain_config_extension(ext), .port_gpio_select(gsel), .counter_status(status));
  jbm_local_chain far (.clock(clock), .shift(tap.shift_dr), .tdi(lp_tdi), .tdo(lp_tdo));
  // ************************************************************
  // clock, timeout, tasks
  // ************************************************************
  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  // whole run needs about 650 cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      end_of_test();
    end
  end
  task step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // capture, n shifts lsb first, update; tdo sampled before each shift edge
  task scan(input jbm_pkg::jbm_dr_sel_e s, input int n, input logic [31:0] d,
            output logic [31:0] o);
    o = '0;
    sel = s;
    tap.capture_dr = 1;
    step(1);
    tap.capture_dr = 0;
    tap.shift_dr = 1;
    for (int i = 0; i < n; i++) begin
      tdi = d[i];
      o[i] = tdo;
      step(1);
    end
    tap.shift_dr = 0;
    tap.update_dr = 1;
    step(1);
    tap.update_dr = 0;
    step(1);
  endtask
  task end_of_test;
    if (bad_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    reset = 1;
    tap = '0;
    sel = jbm_pkg::JBM_SEL_OTHER;
    park = jbm_pkg::JBM_PARKED_IDLE;
    cnt = '0;
    tdi = 0;
    repeat (5) @(posedge clock);
    #1 reset = 0;
    step(1);
    `CHK(status, 1'b0)
    scan(jbm_pkg::JBM_SEL_PRIMARY, 8, 32'h01, q);
    `CHK(q[7:0], 8'h01)
    scan(jbm_pkg::JBM_SEL_EXTENSION, 8, 32'hff, q);
    `CHK(q[7:0], 8'h00)
    scan(jbm_pkg::JBM_SEL_EXTENSION, 8, 32'h01, q);
    `CHK(q[7:0], 8'h07)
    scan(jbm_pkg::JBM_SEL_GPIO, 8, 32'ha5, q);
    `CHK(gsel, 8'ha5)
    scan(jbm_pkg::JBM_SEL_PRIMARY, 8, 32'hff, q);
    `CHK(pri, 8'h7f)
    // bit 3 set only briefly, as a power-saving trial
    for (int p = 1; p < 3; p++) begin
      park = jbm_pkg::jbm_park_e'(p);
      step(1);
      `CHK(tck_en, 1'b0)
    end
    park = jbm_pkg::JBM_UNPARKED;
    step(1);
    `CHK(tck_en, 1'b1)
    scan(jbm_pkg::JBM_SEL_PRIMARY, 8, 32'h65, q);
    `CHK(q[7:0], 8'h7f)
    // ports 0,2,3,4,5 chained: 8 own bits then two per port
    scan(jbm_pkg::JBM_SEL_PRIMARY, 26, 32'h01940065, q);
    `CHK(q[17:10], 8'h65)
    `CHK(q[25:18], 8'h65)
    park = jbm_pkg::JBM_PARKED_IDLE;
    scan(jbm_pkg::JBM_SEL_PRIMARY, 8, 32'h65, q);
    `CHK(q[7:0], 8'h65)
    `CHK(tck_en, 1'b1)
    park = jbm_pkg::JBM_PARKED_RESET;
    step(511);
    `CHK(tck_en, 1'b1)
    step(1);
    `CHK(tck_en, 1'b0)
    park = jbm_pkg::JBM_PARKED_IDLE;
    cnt = 2'b11;
    step(1);
    `CHK(status, 1'b1)
    scan(jbm_pkg::JBM_SEL_PRIMARY, 8, 32'h0c, q);
    `CHK(q[7], 1'b1)
    `CHK(pri[7], 1'b1)
    cnt = 2'b10;
    scan(jbm_pkg::JBM_SEL_COUNTER, 8, 32'h00, q);
    `CHK(status, 1'b0)
    tap.test_logic_reset = 1;
    step(1);
    tap.test_logic_reset = 0;
    `CHK(pri, 8'h01)
    `CHK(ext, 8'h00)
    end_of_test();
  end
endmodule // testbench
